//--- seil_host.sv
/* Host controller and limit switch model.
   Assumes the bench calls drive from its main sequence. */
`timescale 1ns/1ps
module seil_host (
  input logic CLK_SYS,
  output logic SERVO_ENABLE_N, FORWARD_LIMIT_IN, REVERSE_LIMIT_IN, ERROR_PULSE_CLEAR_IN, CMD_FORWARD, CMD_REVERSE
);
  initial {SERVO_ENABLE_N, FORWARD_LIMIT_IN, REVERSE_LIMIT_IN, ERROR_PULSE_CLEAR_IN, CMD_FORWARD, CMD_REVERSE} = 6'h24;
  // Enable, limits and clear first, the motion reference one cycle later
  task drive(input logic [5:0] v);
    @(negedge CLK_SYS);
    {SERVO_ENABLE_N, FORWARD_LIMIT_IN, REVERSE_LIMIT_IN, ERROR_PULSE_CLEAR_IN} = v[5:2];
    @(negedge CLK_SYS);
    {CMD_FORWARD, CMD_REVERSE} = v[1:0];
  endtask
endmodule

//--- seil_pkg.sv
/*
  Package for the servo enable and over-travel interlock.
  Holds setting field positions, reset values, stop modes and timing.
  Assumes a single 250 MHz drive clock.
*/
package seil_pkg;
  localparam int SEIL_CLK_MHZ = 250;
  localparam int SEIL_SYNC_STAGES = 2;
  // Digit positions inside the setting words (4 bits per digit)
  localparam int SEIL_FN_ENSRC_LSB = 0;
  localparam int SEIL_DIR_LSB = 0;
  localparam int SEIL_STOP_LSB = 0;
  localparam logic [15:0] SEIL_FN_RESET = 16'h0000;
  localparam logic [15:0] SEIL_DIR_RESET = 16'h0000;
  localparam logic [15:0] SEIL_STOP_RESET = 16'h0000;
  localparam logic [3:0] SEIL_ENSRC_EXT = 4'h0;
  localparam logic [3:0] SEIL_ENSRC_AUTO = 4'h1;
  localparam logic [3:0] SEIL_DIR_CCW = 4'h0;
  localparam logic [3:0] SEIL_STOP_ZCLAMP_COAST = 4'h5;
  localparam logic [3:0] SEIL_STOP_ZCLAMP_DB = 4'h4;
  localparam logic [3:0] SEIL_STOP_COAST = 4'h1;
  localparam logic [3:0] SEIL_STOP_DB = 4'h0;
  typedef enum logic [1:0] {SEIL_BRK_NONE, SEIL_BRK_COAST, SEIL_BRK_DYN, SEIL_BRK_PLUG} seil_brake_t;
endpackage

//--- seil_properties.sv
/* Checker for the servo interlock top ports.
   Assumes the settings are taken at the first edge after reset. */
`timescale 1ns/1ps
module seil_properties import seil_pkg::*; (
  // Clock, reset and settings
  input logic CLK_SYS, RESET,
  input logic [15:0] BASIC_FUNCTION_SELECT, DIRECTION_SELECT,
  // Pins and drive state
  input logic SERVO_ENABLE_N, FORWARD_LIMIT_IN, REVERSE_LIMIT_IN, ERROR_PULSE_CLEAR_IN,
  input logic SERVO_READY, CMD_FORWARD, CMD_REVERSE, ENC_PHASE_A_INT,
  // Outputs
  input logic MOTOR_ENERGISE, SHAFT_CCW, SHAFT_CW, FWD_OVERTRAVEL, REV_OVERTRAVEL,
  input logic ERROR_CLEAR, ENCODER_PHASE_A_OUT, ZERO_CLAMP,
  input seil_brake_t BRAKE_MODE
);
  logic rst_q, ok;
  logic [3:0] fn_q, dir_q;
  // Own copy of the settings, valid once ok is high
  always_ff @(posedge CLK_SYS) begin
    rst_q <= RESET;
    ok <= !RESET && (rst_q || ok);
    if (rst_q && !RESET) {fn_q, dir_q} <= {BASIC_FUNCTION_SELECT[3:0], DIRECTION_SELECT[3:0]};
  end
  wire ccw_cmd = (dir_q == 4'h0) ? CMD_FORWARD : CMD_REVERSE;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  // Interlock relations
  ext_on_a: assert property ((ok && fn_q == 4'h0 && !SERVO_ENABLE_N)[*3] |=> MOTOR_ENERGISE)
    else $error("motor not powered");
  ext_off_a: assert property ((ok && fn_q == 4'h0 && SERVO_ENABLE_N)[*3] |=> !MOTOR_ENERGISE)
    else $error("motor powered while disabled");
  auto_on_a: assert property (ok && fn_q == 4'h1 && SERVO_READY |=> MOTOR_ENERGISE)
    else $error("no auto enable");
  fwd_block_a: assert property ((ok && FORWARD_LIMIT_IN)[*3] |=> FWD_OVERTRAVEL && !(dir_q == 4'h0 ? SHAFT_CCW : SHAFT_CW))
    else $error("forward motion into limit");
  rev_block_a: assert property ((ok && REVERSE_LIMIT_IN)[*3] |=> REV_OVERTRAVEL && !(dir_q == 4'h0 ? SHAFT_CW : SHAFT_CCW))
    else $error("reverse motion into limit");
  dir_map_a: assert property ($past(ok) && SHAFT_CCW |-> MOTOR_ENERGISE && $past(ccw_cmd))
    else $error("wrong shaft sense");
  enc_pass_a: assert property (ok |-> ENCODER_PHASE_A_OUT == $past(ENC_PHASE_A_INT))
    else $error("encoder phase altered");
  clr_follow_a: assert property ((ok && !ERROR_PULSE_CLEAR_IN)[*3] |=> ERROR_CLEAR)
    else $error("clear not passed");
  sync_hold_a: assert property (ok && fn_q == 4'h0 && MOTOR_ENERGISE && $rose(SERVO_ENABLE_N) |=> MOTOR_ENERGISE[*2])
    else $error("enable used before two stages");
  cover property (ZERO_CLAMP);
  cover property (BRAKE_MODE == SEIL_BRK_PLUG);
  cover property (SHAFT_CW && FWD_OVERTRAVEL);
  cover property (!MOTOR_ENERGISE && BRAKE_MODE == SEIL_BRK_DYN);
endmodule
bind seil_top seil_properties seil_properties_inst (.*);

//--- seil_sync.sv
/*
  Two-stage synchroniser bank for the discrete inputs.
  Assumes inputs may change at any time relative to the clock.
*/
`timescale 1ns/1ps
module seil_sync #(
  parameter int N = 4
) (
  input wire logic clk,
  input wire logic rst,
  seil_sync_if.dst io
);
  import seil_pkg::*;
  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
  } seil_sync_state_t;
  seil_sync_state_t st_ff, nxt_st;
  // First stage feeds only the second stage
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = io.raw;
    nxt_st.s2 = st_ff.s1;
  end
  // Stages reset high: inactive for enable and clear, active for the limits
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '{s1: '1, s2: '1};
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign io.clean = st_ff.s2;
endmodule

//--- seil_sync_if.sv
/*
  Interface carrying raw and synchronised discrete inputs.
  Assumes the sync module and the top share one clock.
*/
`timescale 1ns/1ps
interface seil_sync_if #(parameter int N = 4);
  logic [N-1:0] raw;
  logic [N-1:0] clean;
  modport src (output raw, input clean);
  modport dst (input raw, output clean);
endinterface

//--- seil_top.sv
/*
  Servo enable and over-travel interlock.
  Gates motor power, maps rotation sense, blocks motion into a limit.
  Assumes settings are static wires; they are latched only at reset release,
  which stands for a power cycle. Single clock, synchronous reset.
*/
`timescale 1ns/1ps
module seil_top (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // Settings
  input wire logic [15:0] BASIC_FUNCTION_SELECT,
  input wire logic [15:0] DIRECTION_SELECT,
  input wire logic [15:0] STOP_METHOD_SELECT,
  // Discrete inputs, enable and clear active low, limits active high
  input wire logic SERVO_ENABLE_N,
  input wire logic FORWARD_LIMIT_IN,
  input wire logic REVERSE_LIMIT_IN,
  input wire logic ERROR_PULSE_CLEAR_IN,
  // Drive state
  input wire logic SERVO_READY,
  input wire logic CMD_FORWARD,
  input wire logic CMD_REVERSE,
  input wire logic ENC_PHASE_A_INT,
  // Outputs
  output logic MOTOR_ENERGISE,
  output logic SHAFT_CCW,
  output logic SHAFT_CW,
  output logic FWD_OVERTRAVEL,
  output logic REV_OVERTRAVEL,
  output logic ERROR_CLEAR,
  output seil_pkg::seil_brake_t BRAKE_MODE,
  output logic ZERO_CLAMP,
  output logic ENCODER_PHASE_A_OUT
);
  import seil_pkg::*;

  typedef struct packed {
    logic armed;
    logic [3:0] ensrc;
    logic [3:0] dir;
    logic [3:0] stop;
    logic energise;
    logic ccw;
    logic cw;
    logic fot;
    logic rot;
    logic eclr;
    logic clamp;
    seil_brake_t brake;
    logic enca;
  } seil_state_t;

  seil_state_t st_ff, nxt_st;
  seil_sync_if #(.N(4)) sif ();
  logic s_en_n, s_fwd, s_rev, s_clr, want_on, fwd_ok, rev_ok, plug;

  // Discrete inputs through the synchroniser bank
  assign sif.raw = {ERROR_PULSE_CLEAR_IN, REVERSE_LIMIT_IN, FORWARD_LIMIT_IN, SERVO_ENABLE_N};
  seil_sync #(.N(4)) u_sync (
    .clk(CLK_SYS),
    .rst(RESET),
    .io(sif)
  );
  assign s_en_n = sif.clean[0];
  assign s_fwd = sif.clean[1];
  assign s_rev = sif.clean[2];
  assign s_clr = sif.clean[3];

  // Interlock decisions
  always_comb begin
    nxt_st = st_ff;
    // Settings latched once after reset release
    if (!st_ff.armed) begin
      nxt_st.armed = 1'b1;
      nxt_st.ensrc = BASIC_FUNCTION_SELECT[SEIL_FN_ENSRC_LSB +: 4];
      nxt_st.dir = DIRECTION_SELECT[SEIL_DIR_LSB +: 4];
      nxt_st.stop = STOP_METHOD_SELECT[SEIL_STOP_LSB +: 4];
    end
    // Enable source select
    if (st_ff.ensrc == SEIL_ENSRC_AUTO) begin
      want_on = SERVO_READY;
    end else begin
      want_on = !s_en_n;
    end
    want_on = want_on && st_ff.armed;
    nxt_st.energise = want_on;
    // Limits tied to logical directions; mapping to shaft below
    fwd_ok = !s_fwd;
    rev_ok = !s_rev;
    nxt_st.fot = s_fwd;
    nxt_st.rot = s_rev;
    // Opposite direction still permitted during over-travel
    if (st_ff.dir == SEIL_DIR_CCW) begin
      nxt_st.ccw = want_on && CMD_FORWARD && fwd_ok;
      nxt_st.cw = want_on && CMD_REVERSE && rev_ok;
    end else begin
      nxt_st.cw = want_on && CMD_FORWARD && fwd_ok;
      nxt_st.ccw = want_on && CMD_REVERSE && rev_ok;
    end
    // Encoder output polarity unaffected by direction setting
    nxt_st.enca = ENC_PHASE_A_INT;
    // Error pulses cleared only by host request
    nxt_st.eclr = !s_clr;
    // Stop method
    plug = (CMD_FORWARD && !fwd_ok) || (CMD_REVERSE && !rev_ok);
    if (!want_on) begin
      if (st_ff.stop == SEIL_STOP_ZCLAMP_COAST || st_ff.stop == SEIL_STOP_COAST) begin
        nxt_st.brake = SEIL_BRK_COAST;
      end else begin
        nxt_st.brake = SEIL_BRK_DYN;
      end
      nxt_st.clamp = 1'b0;
    end else if (plug) begin
      if (st_ff.stop == SEIL_STOP_DB) begin
        nxt_st.brake = SEIL_BRK_DYN;
      end else if (st_ff.stop == SEIL_STOP_COAST) begin
        nxt_st.brake = SEIL_BRK_COAST;
      end else begin
        nxt_st.brake = SEIL_BRK_PLUG;
      end
      nxt_st.clamp = 1'b0;
    end else begin
      nxt_st.brake = SEIL_BRK_NONE;
      // Zero clamp held after over-travel stop while limit persists
      nxt_st.clamp = (s_fwd || s_rev) &&
        (st_ff.stop == SEIL_STOP_ZCLAMP_COAST || st_ff.stop == SEIL_STOP_ZCLAMP_DB);
    end
  end

  // State register
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      st_ff <= '{armed: 1'b0, ensrc: SEIL_FN_RESET[3:0], dir: SEIL_DIR_RESET[3:0],
                 stop: SEIL_STOP_RESET[3:0], energise: 1'b0, ccw: 1'b0, cw: 1'b0,
                 fot: 1'b0, rot: 1'b0, eclr: 1'b0, clamp: 1'b0,
                 brake: SEIL_BRK_NONE, enca: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from flip-flops
  assign MOTOR_ENERGISE = st_ff.energise;
  assign SHAFT_CCW = st_ff.ccw;
  assign SHAFT_CW = st_ff.cw;
  assign FWD_OVERTRAVEL = st_ff.fot;
  assign REV_OVERTRAVEL = st_ff.rot;
  assign ERROR_CLEAR = st_ff.eclr;
  assign BRAKE_MODE = st_ff.brake;
  assign ZERO_CLAMP = st_ff.clamp;
  assign ENCODER_PHASE_A_OUT = st_ff.enca;
endmodule

//--- test_seil_top.sv
/* Self-checking bench for the servo interlock.
   Assumes the host model drives the discrete pins. */
`timescale 1ns/1ps
module test_seil_top;
  import seil_pkg::*;
  `define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; $display("ERROR %0t mismatch", $time); end end
  logic CLK_SYS = 0, RESET = 1, SERVO_READY = 0, ENC_PHASE_A_INT = 1;
  logic [15:0] BASIC_FUNCTION_SELECT = 16'h0000, DIRECTION_SELECT = 16'h0000, STOP_METHOD_SELECT = 16'h0005;
  logic SERVO_ENABLE_N, FORWARD_LIMIT_IN, REVERSE_LIMIT_IN, ERROR_PULSE_CLEAR_IN, CMD_FORWARD, CMD_REVERSE;
  logic MOTOR_ENERGISE, SHAFT_CCW, SHAFT_CW, FWD_OVERTRAVEL, REV_OVERTRAVEL, ERROR_CLEAR, ZERO_CLAMP, ENCODER_PHASE_A_OUT;
  seil_brake_t BRAKE_MODE;
  int errors = 0, n_compared = 0;
  always #2 CLK_SYS = ~CLK_SYS;
  seil_top seil_top_inst (.*);
  seil_host seil_host_inst (.*);
  // Verdict and end of run
  task results;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Reset with new settings, standing in for a power cycle
  task boot(input logic [3:0] fn, dir, stop);
    @(negedge CLK_SYS);
    RESET = 1;
    {BASIC_FUNCTION_SELECT[3:0], DIRECTION_SELECT[3:0], STOP_METHOD_SELECT[3:0]} = {fn, dir, stop};
    repeat (3) @(negedge CLK_SYS);
    RESET = 0;
  endtask
  // Pin vector {enable_n, fwd limit, rev limit, clear_n, cmd fwd, cmd rev}, then settle
  task pins(input logic [5:0] v);
    seil_host_inst.drive(v);
    repeat (3) @(negedge CLK_SYS);
  endtask
  // Watchdog
  initial begin
    #20000;
    errors++;
    results();
  end
  // Main sequence
  initial begin
    boot(4'h0, 4'h0, 4'h5);
    pins(6'h26);
    `CHK(MOTOR_ENERGISE, 1'b0)
    pins(6'h06);
    `CHK({MOTOR_ENERGISE, SHAFT_CCW, SHAFT_CW}, 3'b110)
    `CHK(ENCODER_PHASE_A_OUT, 1'b1)
    pins(6'h16);
    `CHK({FWD_OVERTRAVEL, SHAFT_CCW}, 2'b10)
    `CHK(BRAKE_MODE, SEIL_BRK_PLUG)
    pins(6'h15);
    `CHK(SHAFT_CW, 1'b1)
    pins(6'h10);
    `CHK({ZERO_CLAMP, ERROR_CLEAR}, 2'b11)
    pins(6'h24);
    `CHK({MOTOR_ENERGISE, BRAKE_MODE}, {1'b0, SEIL_BRK_COAST})
    boot(4'h1, 4'h1, 4'h5);
    SERVO_READY = 1;
    pins(6'h26);
    `CHK({MOTOR_ENERGISE, SHAFT_CW, SHAFT_CCW}, 3'b110)
    `CHK(ENCODER_PHASE_A_OUT, 1'b1)
    ENC_PHASE_A_INT = 0;
    pins(6'h2d);
    `CHK({REV_OVERTRAVEL, SHAFT_CCW}, 2'b10)
    `CHK(ENCODER_PHASE_A_OUT, 1'b0)
    BASIC_FUNCTION_SELECT = 16'h0000;
    pins(6'h24);
    `CHK(MOTOR_ENERGISE, 1'b1)
    // Dynamic brake method: servo off and command into a limit
    SERVO_READY = 0;
    boot(4'h0, 4'h0, 4'h0);
    pins(6'h24);
    `CHK({MOTOR_ENERGISE, BRAKE_MODE}, {1'b0, SEIL_BRK_DYN})
    pins(6'h16);
    `CHK({MOTOR_ENERGISE, SHAFT_CCW, BRAKE_MODE}, {2'b10, SEIL_BRK_DYN})
    `CHK(ZERO_CLAMP, 1'b0)
    results();
  end
endmodule
